// File: bus_cycle_pkg.sv
package bus_cycle_pkg;

    // clock and processor rates
    localparam int CLK_HZ = 10_000_000;
    localparam int FAST_HZ = 4_000_000;
    localparam int SLOW_HZ = 2_000_000;
    // t-state length in clocks; a least period, so it rounds up
    localparam int FAST_DIV = (CLK_HZ + FAST_HZ - 1) / FAST_HZ;
    localparam int SLOW_DIV = (CLK_HZ + SLOW_HZ - 1) / SLOW_HZ;

    // register byte offsets
    localparam logic [3:0] CFG_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // configuration field positions
    localparam int CFG_SPEED_BIT = 0;
    localparam int CFG_LATCH_BIT = 1;
    localparam int CFG_FETCH_WAIT_BIT = 2;
    localparam int CFG_MEM_WAIT_BIT = 3;
    localparam int CFG_IO_WAIT_BIT = 4;
    localparam int CFG_ROM_WAIT_BIT = 5;
    localparam int CFG_NMI_LSB = 6;
    localparam int CFG_ROM_EN_BIT = 8;
    localparam int CFG_JUMP_EN_BIT = 9;
    localparam int CFG_ROM_SIZE_LSB = 10;
    localparam int CFG_ROM_ADDR_LSB = 16;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h003f_0fff;

    // reset value: 4 mhz, full latch, fetch and rom waits, nmi to nmi,
    // rom and jump off, 1k part at f000
    localparam logic [31:0] CFG_RESET = 32'h003c_0027;

    // status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_JUMP_BIT = 3;
    localparam int ST_PEND_BIT = 4;
    localparam int ST_ROM_BIT = 5;
    localparam int ST_WARN_LSB = 6;

    // nmi routing codes
    localparam logic [1:0] NMI_TO_NMI = 2'h0;
    localparam logic [1:0] NMI_TO_PWRFAIL = 2'h1;

    // rom size codes
    localparam logic [1:0] ROM_1K = 2'h0;
    localparam logic [1:0] ROM_2K = 2'h1;

    // bus cycle t-states, gray along idle-t1-t2-tw-t3
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1 = 3'h1,
        ST_T2 = 3'h3,
        ST_TW = 3'h2,
        ST_T3 = 3'h6
    } tstate_t;

endpackage

// File: bus_cycle_wait_and_boot_jump.sv
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
module bus_cycle_wait_and_boot_jump (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_start,
    input wire logic [15:0] cpu_addr,
    input wire logic instruction_fetch_cycle,
    input wire logic cpu_io,
    input wire logic cpu_write,
    output logic cpu_clk_en,
    output logic cpu_ready,
    output logic cycle_done,
    output logic [15:0] bus_addr,
    output logic [2:0] bus_status,
    output logic bus_psync,
    output logic bus_stval,
    output logic rom_select,
    input wire logic bus_nmi_n,
    input wire logic bus_pwrfail_n,
    output logic cpu_nmi_n
);
    // matches the rom window on its own size boundary
    function automatic logic rom_match(input logic [15:0] a, input logic [5:0] base,
                                       input logic [1:0] size);
        logic [5:0] m;
        m = (size == bus_cycle_pkg::ROM_1K) ? 6'h3f :
            (size == bus_cycle_pkg::ROM_2K) ? 6'h3e : 6'h3c;
        return ((a[15:10] ^ base) & m) == 6'h00;
    endfunction

    // first byte of the rom window, low straps dropped for larger parts
    function automatic logic [15:0] rom_start(input logic [5:0] base, input logic [1:0] size);
        logic [5:0] m;
        m = (size == bus_cycle_pkg::ROM_1K) ? 6'h3f :
            (size == bus_cycle_pkg::ROM_2K) ? 6'h3e : 6'h3c;
        return {base & m, 10'h000};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration fields
    logic [31:0] cfg_reg;
    logic [31:0] cfg_next;
    logic speed_select_strap;
    logic latch_mode_strap;
    logic fetch_wait_strap;
    logic memory_wait_strap;
    logic io_wait_strap;
    logic rom_wait_strap;
    logic [1:0] nmi_route_strap;
    logic rom_enable;
    logic jump_enable;
    logic [1:0] rom_size;
    logic [5:0] rom_address_straps;
    logic tick;

    assign speed_select_strap = cfg_reg[bus_cycle_pkg::CFG_SPEED_BIT];
    assign latch_mode_strap = cfg_reg[bus_cycle_pkg::CFG_LATCH_BIT];
    assign fetch_wait_strap = cfg_reg[bus_cycle_pkg::CFG_FETCH_WAIT_BIT];
    assign memory_wait_strap = cfg_reg[bus_cycle_pkg::CFG_MEM_WAIT_BIT];
    assign io_wait_strap = cfg_reg[bus_cycle_pkg::CFG_IO_WAIT_BIT];
    assign rom_wait_strap = cfg_reg[bus_cycle_pkg::CFG_ROM_WAIT_BIT];
    assign nmi_route_strap = cfg_reg[bus_cycle_pkg::CFG_NMI_LSB +: 2];
    assign rom_enable = cfg_reg[bus_cycle_pkg::CFG_ROM_EN_BIT];
    assign jump_enable = cfg_reg[bus_cycle_pkg::CFG_JUMP_EN_BIT];
    assign rom_size = cfg_reg[bus_cycle_pkg::CFG_ROM_SIZE_LSB +: 2];
    assign rom_address_straps = cfg_reg[bus_cycle_pkg::CFG_ROM_ADDR_LSB +: 6];

    // t-state enable at the selected processor speed
    tstate_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .fast(speed_select_strap),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // request capture and bus cycle sequencer
    bus_cycle_pkg::tstate_t state_reg;
    bus_cycle_pkg::tstate_t state_next;
    logic pend_reg, pend_next;
    logic [15:0] req_addr_reg, req_addr_next;
    logic req_fetch_reg, req_fetch_next;
    logic req_io_reg, req_io_next;
    logic req_wr_reg, req_wr_next;
    logic req_rom_reg, req_rom_next;
    logic jump_pending_reg, jump_pending_next;
    logic [15:0] bus_addr_next;
    logic [2:0] bus_status_next;
    logic need_wait;
    logic take;
    logic [15:0] eff_addr;

    // requests are taken only while idle with nothing pending
    assign take = cpu_start && (state_reg == bus_cycle_pkg::ST_IDLE) && !pend_reg;

    // every memory cycle counts for the memory option, fetches included
    assign need_wait = (req_fetch_reg && fetch_wait_strap)
                    || (!req_io_reg && memory_wait_strap)
                    || (req_io_reg && io_wait_strap)
                    || (req_rom_reg && rom_wait_strap);

    always_comb begin
        state_next = state_reg;
        pend_next = pend_reg;
        req_addr_next = req_addr_reg;
        req_fetch_next = req_fetch_reg;
        req_io_next = req_io_reg;
        req_wr_next = req_wr_reg;
        req_rom_next = req_rom_reg;
        jump_pending_next = jump_pending_reg;
        bus_addr_next = bus_addr;
        bus_status_next = bus_status;
        eff_addr = cpu_addr;
        // the first fetch after reset is steered to the shared start address
        if (jump_pending_reg && jump_enable && instruction_fetch_cycle) begin
            eff_addr = rom_start(rom_address_straps, rom_size);
        end
        if (take) begin
            pend_next = 1'b1;
            req_addr_next = eff_addr;
            req_fetch_next = instruction_fetch_cycle;
            req_io_next = cpu_io;
            req_wr_next = cpu_write;
            // rom off: the jump address lands in main memory
            req_rom_next = !cpu_io && rom_enable
                        && rom_match(eff_addr, rom_address_straps, rom_size);
            if (instruction_fetch_cycle) begin
                jump_pending_next = 1'b0;
            end
            // partial latch passes the address at once, ahead of t1
            if (!latch_mode_strap) begin
                bus_addr_next = eff_addr;
                bus_status_next = {instruction_fetch_cycle, cpu_io, cpu_write};
            end
        end
        if (tick) begin
            unique case (state_reg)
                bus_cycle_pkg::ST_IDLE: begin
                    if (pend_reg) begin
                        state_next = bus_cycle_pkg::ST_T1;
                        pend_next = 1'b0;
                        // full latch changes outputs only here
                        if (latch_mode_strap) begin
                            bus_addr_next = req_addr_reg;
                            bus_status_next = {req_fetch_reg, req_io_reg, req_wr_reg};
                        end
                    end
                end
                bus_cycle_pkg::ST_T1: state_next = bus_cycle_pkg::ST_T2;
                bus_cycle_pkg::ST_T2: begin
                    state_next = need_wait ? bus_cycle_pkg::ST_TW
                                           : bus_cycle_pkg::ST_T3;
                end
                bus_cycle_pkg::ST_TW: state_next = bus_cycle_pkg::ST_T3;
                bus_cycle_pkg::ST_T3: state_next = bus_cycle_pkg::ST_IDLE;
                default: state_next = bus_cycle_pkg::ST_IDLE;
            endcase
        end
    end

    // address and status only load at the two points above
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= bus_cycle_pkg::ST_IDLE;
            pend_reg <= 1'b0;
            req_addr_reg <= 16'h0000;
            req_fetch_reg <= 1'b0;
            req_io_reg <= 1'b0;
            req_wr_reg <= 1'b0;
            req_rom_reg <= 1'b0;
            jump_pending_reg <= 1'b1;
            bus_addr <= 16'h0000;
            bus_status <= 3'h0;
        end else begin
            state_reg <= state_next;
            pend_reg <= pend_next;
            req_addr_reg <= req_addr_next;
            req_fetch_reg <= req_fetch_next;
            req_io_reg <= req_io_next;
            req_wr_reg <= req_wr_next;
            req_rom_reg <= req_rom_next;
            jump_pending_reg <= jump_pending_next;
            bus_addr <= bus_addr_next;
            bus_status <= bus_status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus strobes, ready, nmi route
    logic psync_next, stval_next, ready_next, done_next, nmi_next, rom_sel_next;
    logic t3_end;
    assign t3_end = tick && (state_reg == bus_cycle_pkg::ST_T3);

    always_comb begin
        psync_next = (state_next == bus_cycle_pkg::ST_T1);
        stval_next = (state_next == bus_cycle_pkg::ST_T2);
        ready_next = (state_next != bus_cycle_pkg::ST_TW);
        done_next = t3_end;
        rom_sel_next = (state_next != bus_cycle_pkg::ST_IDLE) && req_rom_reg;
        unique case (nmi_route_strap)
            bus_cycle_pkg::NMI_TO_NMI: nmi_next = bus_nmi_n;
            bus_cycle_pkg::NMI_TO_PWRFAIL: nmi_next = bus_pwrfail_n;
            default: nmi_next = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_psync <= 1'b0;
            bus_stval <= 1'b0;
            cpu_ready <= 1'b1;
            cycle_done <= 1'b0;
            rom_select <= 1'b0;
            cpu_nmi_n <= 1'b1;
            cpu_clk_en <= 1'b0;
        end else begin
            bus_psync <= psync_next;
            bus_stval <= stval_next;
            cpu_ready <= ready_next;
            cycle_done <= done_next;
            rom_select <= rom_sel_next;
            cpu_nmi_n <= nmi_next;
            cpu_clk_en <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle per access, answer on the second edge
    logic wait_next;
    logic [31:0] rdata_next;
    logic [3:0] byte_addr;
    logic [2:0] warn;
    logic [31:0] status_word;
    assign byte_addr = {avs_address, 2'b00};
    // advisory flags for risky speed, latch and wait mixes
    assign warn = {speed_select_strap && rom_enable && !rom_wait_strap,
                   speed_select_strap && latch_mode_strap && !fetch_wait_strap
                       && !memory_wait_strap,
                   speed_select_strap && latch_mode_strap && !fetch_wait_strap
                       && !memory_wait_strap && !io_wait_strap};
    assign status_word = {23'h000000, warn, rom_select, pend_reg, jump_pending_reg,
                          3'(state_reg)};

    always_comb begin
        wait_next = 1'b1;
        rdata_next = avs_readdata;
        cfg_next = cfg_reg;
        if ((avs_read || avs_write) && avs_waitrequest) begin
            wait_next = 1'b0;
            // read data loaded one edge ahead so it stands at the answer
            rdata_next = (byte_addr == bus_cycle_pkg::CFG_OFFSET) ? cfg_reg :
                         (byte_addr == bus_cycle_pkg::STATUS_OFFSET) ? status_word : 32'h0;
        end
        // write lands at the edge that sees waitrequest low
        if (avs_write && !avs_waitrequest && byte_addr == bus_cycle_pkg::CFG_OFFSET) begin
            cfg_next = avs_writedata & bus_cycle_pkg::CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= bus_cycle_pkg::CFG_RESET;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            cfg_reg <= cfg_next;
            avs_waitrequest <= wait_next;
            avs_readdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence t2_end_s;
        state_reg == bus_cycle_pkg::ST_T2 && tick;
    endsequence

    a_speed_fast: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_clk_en && speed_select_strap && $stable(speed_select_strap)
            |=> !cpu_clk_en ##1 !cpu_clk_en ##1 (cpu_clk_en || !speed_select_strap)) // slow only stretches
        else $error("fast t-state period wrong");
    a_wait_inserted: assert property (@(posedge clk) disable iff (!rst_n)
        t2_end_s and need_wait |=> state_reg == bus_cycle_pkg::ST_TW && !cpu_ready)
        else $error("wait state not inserted");
    a_mem_wait_fetch: assert property (@(posedge clk) disable iff (!rst_n)
        t2_end_s and (memory_wait_strap && !req_io_reg) |=> state_reg == bus_cycle_pkg::ST_TW)
        else $error("memory wait missed a memory cycle");
    a_rom_wait_gate: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == bus_cycle_pkg::ST_TW && !fetch_wait_strap && !memory_wait_strap
            && !io_wait_strap |-> rom_enable && rom_select)
        else $error("rom wait without enabled rom");
    a_wait_one_tstate: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == bus_cycle_pkg::ST_TW && tick |=> state_reg == bus_cycle_pkg::ST_T3 && cpu_ready)
        else $error("wait longer than one t-state");
    a_jump_target: assert property (@(posedge clk) disable iff (!rst_n)
        take && jump_pending_reg && jump_enable && instruction_fetch_cycle
            |=> req_addr_reg == rom_start(rom_address_straps, rom_size) && !jump_pending_reg)
        else $error("reset jump address wrong");
    a_jump_once: assert property (@(posedge clk) disable iff (!rst_n)
        !jump_pending_reg |=> !jump_pending_reg)
        else $error("jump rearmed after use");
    a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg != bus_cycle_pkg::ST_IDLE && $past(state_reg) != bus_cycle_pkg::ST_IDLE
            |-> $stable(bus_addr) && $stable(bus_status))
        else $error("bus address moved inside a cycle");
    a_full_change_pt: assert property (@(posedge clk) disable iff (!rst_n)
        latch_mode_strap && $past(latch_mode_strap) && $changed(bus_addr)
            |-> state_reg == bus_cycle_pkg::ST_T1 && $past(state_reg) == bus_cycle_pkg::ST_IDLE)
        else $error("full latch changed outside t1 entry");
    a_nmi_none: assert property (@(posedge clk) disable iff (!rst_n)
        nmi_route_strap == 2'h2 |=> cpu_nmi_n)
        else $error("nmi passed while disconnected");
    a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("avalon answer timing wrong");
endmodule // bus_cycle_wait_and_boot_jump

// File: mem_board_model.sv
`timescale 1ns/100ps
// memory board on the far side: opens its cycle on the strobe that suits the latch mode
module mem_board_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] bus_addr,
    input wire logic [2:0] bus_status,
    input wire logic bus_psync,
    input wire logic bus_stval,
    input wire logic latch_full,
    input wire logic nmi_req,
    input wire logic pf_req,
    output logic bus_nmi_n,
    output logic bus_pwrfail_n,
    output logic [15:0] start_addr
);
    logic psync_reg, stval_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // edge detect on strobes; partial mode starts early and must abort io cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psync_reg <= 1'b0;
            stval_reg <= 1'b0;
            start_addr <= 16'h0000;
        end else begin
            psync_reg <= bus_psync;
            stval_reg <= bus_stval;
            if (!latch_full && bus_psync && !psync_reg) begin
                start_addr <= bus_addr;
            end
            if (latch_full && bus_stval && !stval_reg) begin
                start_addr <= bus_addr;
            end
            if (!latch_full && bus_stval && !stval_reg && bus_status[1]) begin
                start_addr <= 16'hffff; // aborted: turned out to be io
            end
        end
    end
    // bus interrupt lines, active low, driven on request of the bench
    assign bus_nmi_n = !nmi_req;
    assign bus_pwrfail_n = !pf_req;
endmodule // mem_board_model

// File: none_placeholder_removed.sv
`timescale 1ns/100ps

// File: tb.sv
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [1:0] avs_address = 2'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, cur;
    logic cpu_start = 1'b0, instruction_fetch_cycle = 1'b0, cpu_io = 1'b0, cpu_write = 1'b0;
    logic [15:0] cpu_addr = 16'h0, bus_addr, start_addr, early, done_addr, prev;
    logic cpu_clk_en, cpu_ready, cycle_done, bus_psync, bus_stval, rom_select, cpu_nmi_n;
    logic bus_nmi_n, bus_pwrfail_n, rom_seen, latch_full = 1'b1, nmi_req = 1'b0, pf_req = 1'b0;
    logic [2:0] bus_status;
    int n_mismatch = 0, n_compared = 0, low_clks, gap, last, moved;
    always #50 clk = ~clk;

    bus_cycle_wait_and_boot_jump DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_start(cpu_start),
        .cpu_addr(cpu_addr), .instruction_fetch_cycle(instruction_fetch_cycle),
        .cpu_io(cpu_io), .cpu_write(cpu_write), .cpu_clk_en(cpu_clk_en), .cpu_ready(cpu_ready),
        .cycle_done(cycle_done), .bus_addr(bus_addr), .bus_status(bus_status),
        .bus_psync(bus_psync), .bus_stval(bus_stval), .rom_select(rom_select),
        .bus_nmi_n(bus_nmi_n), .bus_pwrfail_n(bus_pwrfail_n), .cpu_nmi_n(cpu_nmi_n));
    mem_board_model far_side (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_status(bus_status), .bus_psync(bus_psync), .bus_stval(bus_stval),
        .latch_full(latch_full), .nmi_req(nmi_req), .pf_req(pf_req), .bus_nmi_n(bus_nmi_n),
        .bus_pwrfail_n(bus_pwrfail_n), .start_addr(start_addr));

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and comparison helpers
    task automatic stop_test;
        if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hang;
        n_mismatch++;
        $display("unexpected handshake: expected answer seen none");
        stop_test;
    endtask
    // strap word in field order: rom addr, size, jump, rom, nmi, waits, latch, speed
    function automatic logic [31:0] cfg(input logic sp, la, fw, mw, iw, rw,
        input logic [1:0] nm, input logic re, je, input logic [1:0] sz, input logic [5:0] ra);
        cfg = {10'h000, ra, 4'h0, sz, je, re, nm, rw, iw, mw, fw, la, sp};
    endfunction
    // memory wait covers fetches too; rom wait needs the rom enabled and a hit
    function automatic logic exp_wait(input logic [31:0] c, input logic f, io, hit);
        exp_wait = (f & c[2]) | (!io & c[3]) | (io & c[4]) | (hit & c[5] & c[8]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // avalon master: hold until waitrequest is seen low at a rising edge
    task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) hang;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic setcfg(input logic [31:0] c);
        av(1'b1, 2'h0, c);
        cur = c;
        latch_full <= c[1];
    endtask
    // one processor bus cycle; collects wait clocks, tick spacing and address moves
    task automatic cyc(input logic [15:0] a, input logic f, input logic io);
        int i;
        prev = bus_addr;
        @(posedge clk);
        cpu_start <= 1'b1;
        cpu_addr <= a;
        instruction_fetch_cycle <= f;
        cpu_io <= io;
        cpu_write <= io;
        @(posedge clk);
        cpu_start <= 1'b0;
        low_clks = 0; rom_seen = 1'b0; last = -1; gap = 0; moved = 0;
        @(negedge clk);
        early = bus_addr;
        for (i = 0; i < 200; i++) begin
            if (cpu_ready === 1'b0) low_clks++;
            if (rom_select === 1'b1) rom_seen = 1'b1;
            if (bus_addr !== prev && bus_psync !== 1'b1) moved++;
            prev = bus_addr;
            if (cpu_clk_en === 1'b1) begin
                if (last >= 0) gap = i - last;
                last = i;
            end
            if (cycle_done === 1'b1) break;
            @(negedge clk);
        end
        if (i == 200) hang;
        done_addr = bus_addr;
    endtask
    task automatic wcase(input logic [15:0] a, input logic f, io, hit);
        int dv;
        dv = cur[0] ? bus_cycle_pkg::FAST_DIV : bus_cycle_pkg::SLOW_DIV;
        cyc(a, f, io);
        check("wait clocks", 32'(low_clks), exp_wait(cur, f, io, hit) ? 32'(dv) : 32'h0);
        check("rom select", 32'(rom_seen), 32'(hit & cur[8]));
        check("tick gap", 32'(gap), 32'(dv));
        check("bus address", 32'(done_addr), 32'(a));
        check("bus status", 32'(bus_status), 32'({f, io, io}));
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int s, k, z;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        av(1'b0, 2'h0, 32'h0);
        check("config reset", rd, bus_cycle_pkg::CFG_RESET);
        cur = bus_cycle_pkg::CFG_RESET;
        wcase(16'h1000, 1'b1, 1'b0, 1'b0);
        wcase(16'h1000, 1'b0, 1'b0, 1'b0);
        wcase(16'h0040, 1'b0, 1'b1, 1'b0);
        // writable bits, unmapped word
        av(1'b1, 2'h0, 32'hffff_ffff);
        av(1'b1, 2'h2, 32'h0);
        av(1'b0, 2'h0, 32'h0);
        check("config mask", rd, bus_cycle_pkg::CFG_WRITE_MASK);
        av(1'b0, 2'h2, 32'h0);
        check("unmapped read", rd, 32'h0);
        // each wait option alone at both speeds, rom left off
        for (s = 0; s < 2; s++) begin
            for (k = 0; k < 4; k++) begin
                setcfg(cfg(s[0], 1'b1, k == 0, k == 1, k == 2, k == 3, 2'h0, 1'b0, 1'b0, 2'h0, 6'h3c));
                wcase(16'hf000, 1'b1, 1'b0, 1'b0);
                wcase(16'hf000, 1'b0, 1'b0, 1'b0);
                wcase(16'h00f0, 1'b0, 1'b1, 1'b0);
            end
        end
        // rom decode at f000 for every part size
        for (z = 0; z < 3; z++) begin
            setcfg(cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0, z[1:0], 6'h3c));
            wcase(16'hf000, 1'b0, 1'b0, 1'b1);
            wcase(16'hf400, 1'b0, 1'b0, z > 0);
            wcase(16'hf800, 1'b0, 1'b0, z == 2);
            wcase(16'he000, 1'b0, 1'b0, 1'b0);
        end
        av(1'b0, 2'h1, 32'h0);
        check("status advice", rd, 32'h0000_00c0);
        // partial latch: address early, board starts on psync
        setcfg(cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 6'h3c));
        cyc(16'h1234, 1'b0, 1'b0);
        check("partial early address", 32'(early), 32'h1234);
        check("board start partial", 32'(start_addr), 32'h1234);
        cyc(16'h00f0, 1'b0, 1'b1);
        check("board abort io", 32'(start_addr), 32'hffff);
        // full latch: address moves only with psync
        setcfg(cfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 6'h3c));
        cyc(16'h5678, 1'b0, 1'b0);
        check("full latch moves", 32'(moved), 32'h0);
        check("board start full", 32'(start_addr), 32'h5678);
        // auto boot into rom, then normal addressing
        do_reset;
        setcfg(cfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 2'h0, 6'h3c));
        cyc(16'h0123, 1'b1, 1'b0);
        check("jump to rom", 32'(done_addr), 32'hf000);
        check("jump rom select", 32'(rom_seen), 32'h1);
        cyc(16'h0123, 1'b1, 1'b0);
        check("after jump", 32'(done_addr), 32'h0123);
        // jump into main memory with the rom off
        do_reset;
        setcfg(cfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b1, 2'h0, 6'h09));
        cyc(16'h0123, 1'b1, 1'b0);
        check("jump to memory", 32'(done_addr), 32'h2400);
        check("memory jump select", 32'(rom_seen), 32'h0);
        // every nmi route against each bus line
        for (k = 0; k < 4; k++) begin
            setcfg(cfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, k[1:0], 1'b0, 1'b0, 2'h0, 6'h3c));
            for (s = 0; s < 2; s++) begin
                nmi_req <= (s == 0);
                pf_req <= (s == 1);
                repeat (3) @(posedge clk);
                check("nmi route", 32'(cpu_nmi_n), 32'(!((k == 0 && s == 0) || (k == 1 && s == 1))));
            end
            nmi_req <= 1'b0;
            pf_req <= 1'b0;
        end
        stop_test;
    end
endmodule // tb

// File: tstate_divider.sv
`timescale 1ns/100ps
module tstate_divider #(
    parameter int FAST = bus_cycle_pkg::FAST_DIV,
    parameter int SLOW = bus_cycle_pkg::SLOW_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fast,
    output logic tick
);
    // elaboration stops on ratios that the 8-bit counter cannot serve
    if (FAST < 2 || SLOW < FAST || SLOW > 255) begin : g_bad_ratio
        $error("tstate_divider: unusable division ratios");
    end

    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic tick_next;

    // a speed change mid-period is absorbed by the >= compare
    always_comb begin
        count_next = count_reg + 8'h01;
        tick_next = 1'b0;
        if (count_reg >= (fast ? 8'(FAST - 1) : 8'(SLOW - 1))) begin
            count_next = 8'h00;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 8'h00;
            tick <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick <= tick_next;
        end
    end
endmodule // tstate_divider
